// ### inc/metering_pkg.sv
package metering_pkg;

    // ************************************************************
    // Clock, sampling and channel widths
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int NOMINAL_CLK_HZ = 4_194_304;
    localparam int SAMPLE_DIV = 4;
    localparam int VOLT_W = 11;
    localparam int CURR_W = 16;
    localparam int DECIM_N = 32;
    localparam int LP_SHIFT = 5;
    localparam int DC_SHIFT = 10;
    // Decimation gains 1.004 and 0.502 as 257/256 and 257/512.
    localparam int VOLT_GAIN_NUM = 257;
    localparam int VOLT_GAIN_SH = 8;
    localparam int CURR_GAIN_NUM = 257;
    localparam int CURR_GAIN_SH = 9;
    localparam logic [5:0] VOLT_AMP_GAIN = 6'h04;
    localparam logic [5:0] CURR_PRE_GAIN = 6'h04;

    // ************************************************************
    // Line period and RMS limits
    // ************************************************************
    localparam int LOW_FREQ_CNT = 2 ** 17;
    localparam int HIGH_FREQ_CNT = 2 ** 15;
    localparam logic [1:0] HIGH_FREQ_REPEAT = 2'h3;
    localparam int RMS_SHIFT = 8;
    localparam logic [8:0] KV_BASE = 9'h0e0;
    localparam logic [5:0] KV_CODE_MAX = 6'h20;
    // Thresholds in code units times Kv*256: 64*1023*256/(0.3*den).
    localparam int RMS_THR_SHUNT = (64 * 1023 * 256 * 10) / (3 * 6703);
    localparam int RMS_THR_COIL = (64 * 1023 * 256 * 10) / (3 * 6687);
    localparam logic [39:0] RMS_ON_SHUNT = 40'(RMS_THR_SHUNT * RMS_THR_SHUNT);
    localparam logic [39:0] RMS_ON_COIL = 40'(RMS_THR_COIL * RMS_THR_COIL);

    // ************************************************************
    // Output pulse timing and channel multiplexing
    // ************************************************************
    localparam int PULSE_TIME_US = 1000;
    localparam int PULSE_CYCLES = PULSE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int MUX_SAMPLES = 4096;

    // ************************************************************
    // Register map, fields and reset values
    // ************************************************************
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PULSE_CONST = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0c;
    localparam logic [7:0] OFS_SAMPLES = 8'h10;
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_EXTRA_BIT = 2;
    localparam int CFG_TWO_CH_BIT = 3;
    localparam int CFG_FUND_BIT = 4;
    localparam int CFG_KV_LSB = 8;
    localparam int CFG_LOCK_BIT = 31;
    localparam logic [31:0] CONFIG_RST = 32'h0000_2000;
    localparam logic [31:0] PULSE_CONST_RST = 32'h0001_0000;

endpackage

// ### rtl/sd_decimator.sv
`timescale 1ns/1ns
`default_nettype none

module sd_decimator
    import metering_pkg::*;
#(
    parameter int OUT_W = 16,
    parameter int GAIN_NUM = 257,
    parameter int GAIN_SH = 9
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sampleEn,
    input wire logic bitIn,
    output logic signed [OUT_W-1:0] sampleOut,
    output logic sampleValid
);

    localparam int SW = OUT_W + 2;
    localparam logic signed [SW-1:0] FULL = SW'((2 ** (OUT_W - 1)) - 1);
    localparam logic signed [SW-1:0] MAXV = SW'((2 ** (OUT_W - 1)) - 1);
    localparam logic signed [SW-1:0] MINV = -MAXV;
    localparam logic signed [10:0] GN = 11'(GAIN_NUM);
    localparam logic [5:0] DEC_LAST = 6'(DECIM_N - 1);

    logic signed [SW-1:0] lp_q;
    logic signed [SW-1:0] dc_q;
    logic [5:0] cnt_q;

    // Integrate the one-bit stream as +/-FULL into a single-pole low pass.
    wire signed [SW-1:0] target = bitIn ? FULL : -FULL;
    wire signed [SW-1:0] lpStep = (target - lp_q) >>> LP_SHIFT;
    // DC offset tracks slowly, so the line waveform itself passes untouched.
    wire signed [SW-1:0] hp = lp_q - dc_q;
    wire signed [SW+10:0] prod = hp * GN;
    wire signed [SW+10:0] scaled = prod >>> GAIN_SH;
    wire decim = sampleEn && (cnt_q == DEC_LAST);
    wire signed [OUT_W-1:0] clipped = (scaled > MAXV) ? MAXV[OUT_W-1:0] :
        (scaled < MINV) ? MINV[OUT_W-1:0] : scaled[OUT_W-1:0];

    // Filter, offset removal and output register, one decimated word per DECIM_N bits.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            lp_q <= '0;
            dc_q <= '0;
            cnt_q <= '0;
            sampleOut <= '0;
            sampleValid <= 1'b0;
        end
        else
        begin
            sampleValid <= decim;
            if (sampleEn)
            begin
                lp_q <= lp_q + lpStep;
                cnt_q <= decim ? 6'h00 : cnt_q + 6'h01;
            end
            if (decim)
            begin
                dc_q <= dc_q + (hp >>> DC_SHIFT);
                sampleOut <= clipped;
            end
        end
    end

endmodule

`default_nettype wire

// ### rtl/line_period_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module line_period_monitor
    import metering_pkg::*;
#(
    parameter int LOW_CNT = LOW_FREQ_CNT,
    parameter int HIGH_CNT = HIGH_FREQ_CNT,
    parameter int CNT_W = 18
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic signed [VOLT_W-1:0] sample,
    output logic [CNT_W-1:0] periodCount,
    output logic lowFreq,
    output logic highFreq
);

    logic signed [VOLT_W-1:0] prev_q;
    logic rising_q;
    logic marker_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0] streak_q;

    // A peak is a positive sample after which the waveform stops rising.
    wire peak = sampleValid && rising_q && (sample <= prev_q) && (prev_q > 0);
    wire trailing = sampleValid && marker_q && !peak;
    wire cntFull = &cnt_q;
    wire tooSlow = cnt_q > CNT_W'(LOW_CNT);
    wire tooFast = cnt_q < CNT_W'(HIGH_CNT);

    // Peak marker stays high for one decimated sample.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            prev_q <= '0;
            rising_q <= 1'b0;
            marker_q <= 1'b0;
        end
        else if (sampleValid)
        begin
            prev_q <= sample;
            rising_q <= sample > prev_q;
            marker_q <= peak;
        end
    end

    // Period counter between trailing marker edges, with the range checks.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
            periodCount <= '0;
            lowFreq <= 1'b0;
            highFreq <= 1'b0;
            streak_q <= 2'h0;
        end
        else if (trailing)
        begin
            cnt_q <= CNT_W'(1);
            periodCount <= cnt_q;
            lowFreq <= tooSlow;
            if (tooFast)
            begin
                streak_q <= (streak_q == HIGH_FREQ_REPEAT) ? streak_q : streak_q + 2'h1;
                highFreq <= highFreq || (streak_q == HIGH_FREQ_REPEAT - 2'h1);
            end
            else
            begin
                streak_q <= 2'h0;
                highFreq <= 1'b0;
            end
        end
        else
        begin
            cnt_q <= cntFull ? cnt_q : cnt_q + CNT_W'(1);
            if (tooSlow)
            begin
                lowFreq <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### rtl/metering_front_end.sv
// Operation
// - Voltage amplifier gain fixed at four.
// - Current gain: preamp four times PGA two..eight.
// - Gain select bits; channels may differ.
// - Single channel gain decode table.
// - Two channel decode; value three splits gains.
// - Two current inputs share one path.
// - Voltage and current converted simultaneously.
// - One bit per sample at clock/4.
// - Decimate, integrate, remove DC automatically.
// - Filter gain 1.004 voltage, 0.502 current.
// - Results eleven and sixteen bits wide.
// - Marker pulse at each positive peak.
// - Slow or stalled period sets error.
// - Fast line needs three periods in row.
// - Low RMS voltage sets error.
// - Low RMS clears above twice threshold.
// - Error suspends power, blanks pulse outputs.
// - Pulse output wide-band or fundamental energy.
// - Drive stepper, flag negative power.
// - Calibration cells cannot change once locked, until reset.
// - Timing derived from the system clock.
`timescale 1ns/1ns
`default_nettype none

module metering_front_end
    import metering_pkg::*;
#(
    parameter int LOW_CNT = LOW_FREQ_CNT,
    parameter int HIGH_CNT = HIGH_FREQ_CNT,
    parameter int PULSE_LEN = PULSE_CYCLES,
    parameter int MUX_LEN = MUX_SAMPLES
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic voltBitPin,
    input wire logic currBitPin,
    output logic currSecondarySel,
    output logic [1:0] pgaCode,
    output logic baseFreqRangeError,
    output logic stepperDrivePos,
    output logic stepperDriveNeg,
    output logic energyPulseOut,
    output logic negativePower
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Total current gain (8..32) for one channel from the select bits.
    function automatic logic [5:0] currGain(input logic [1:0] sel, input logic extra,
                                            input logic secondary);
        logic [5:0] g;
        g = 6'h08;
        case (sel)
            2'h0: g = extra ? 6'h10 : 6'h08;
            2'h1: g = extra ? 6'h20 : 6'h18;
            2'h2: g = 6'h08;
            2'h3: g = secondary ? 6'h20 : 6'h08;
            default: g = 6'h08;
        endcase
        return g;
    endfunction

    // PGA code 0..3 for stage gains 2, 4, 6, 8 given the total gain.
    function automatic logic [1:0] pgaOf(input logic [5:0] gain);
        logic [2:0] q;
        q = gain[5:3] - 3'h1;
        return q[1:0];
    endfunction

    // ************************************************************
    // Register bus slave
    // ************************************************************
    logic [31:0] config_q;
    logic [31:0] pulseConst_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;

    wire addrPhase = hsel && htrans[1] && hready;
    wire locked = config_q[CFG_LOCK_BIT];
    wire [1:0] sensorGainSelect = config_q[CFG_GAIN_LSB +: 2];
    wire extraGainBit = config_q[CFG_EXTRA_BIT];
    wire twoChannel = config_q[CFG_TWO_CH_BIT];
    wire fundamentalSel = config_q[CFG_FUND_BIT];
    wire [5:0] kvRaw = config_q[CFG_KV_LSB +: 6];
    wire [5:0] kvCode = (kvRaw > KV_CODE_MAX) ? KV_CODE_MAX : kvRaw;
    wire [8:0] voltageCalibrator = KV_BASE + {3'h0, kvCode};
    wire coilSensor = !sensorGainSelect[1];

    // Status and sample words that software reads.
    logic lowRms_q;
    logic lowFreq;
    logic highFreq;
    logic [17:0] periodCount;
    logic signed [VOLT_W-1:0] vSample;
    logic signed [CURR_W-1:0] iSample;
    logic vValid;
    logic iValid;
    // A lone current channel on value three is the shunt, so it takes the shunt gain.
    wire [5:0] primGain = currGain(sensorGainSelect, extraGainBit, !twoChannel);
    wire [5:0] secGain = twoChannel ? currGain(sensorGainSelect, extraGainBit, 1'b1) : primGain;
    wire [31:0] statusWord = {VOLT_AMP_GAIN, CURR_PRE_GAIN, secGain, primGain, 2'h0,
                              currSecondarySel, negativePower, lowRms_q, highFreq, lowFreq,
                              baseFreqRangeError};
    wire [31:0] sampleWord = {iSample, 5'h00, vSample};
    wire [31:0] rdMux = (haddr[7:0] == OFS_CONFIG) ? config_q :
        (haddr[7:0] == OFS_PULSE_CONST) ? pulseConst_q :
        (haddr[7:0] == OFS_STATUS) ? statusWord :
        (haddr[7:0] == OFS_PERIOD) ? {14'h0000, periodCount} :
        (haddr[7:0] == OFS_SAMPLES) ? sampleWord : 32'h0000_0000;

    // Zero wait states; every access finishes with an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Address phase is latched; write data lands in the following cycle.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite;
            if (addrPhase)
            begin
                wrAddr_q <= haddr[7:0];
                hrdata_q <= hwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    // Calibration words behave as one-time cells: the lock bit freezes them until reset.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            config_q <= CONFIG_RST;
            pulseConst_q <= PULSE_CONST_RST;
        end
        else if (wrPend_q && !locked)
        begin
            if (wrAddr_q == OFS_CONFIG)
            begin
                config_q <= hwdata;
            end
            if (wrAddr_q == OFS_PULSE_CONST)
            begin
                pulseConst_q <= hwdata;
            end
        end
    end

    // ************************************************************
    // Sampling clock, pin synchronisers and channel multiplexer
    // ************************************************************
    logic [1:0] div_q;
    logic [1:0] vSync_q;
    logic [1:0] iSync_q;
    logic sampleEn_q;
    logic [12:0] muxCnt_q;

    // timing counts in system clocks, except the mux dwell in current samples
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            div_q <= 2'h0;
            sampleEn_q <= 1'b0;
            vSync_q <= 2'h0;
            iSync_q <= 2'h0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            sampleEn_q <= div_q == 2'(SAMPLE_DIV - 1);
            vSync_q <= {vSync_q[0], voltBitPin};
            iSync_q <= {iSync_q[0], currBitPin};
        end
    end

    // The shared path carries the previous channel's state for a short while after
    // each switch; the slow dwell keeps that settling small against the energy sums.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            muxCnt_q <= 13'h0000;
            currSecondarySel <= 1'b0;
            pgaCode <= 2'h0;
        end
        else
        begin
            pgaCode <= pgaOf(currSecondarySel ? secGain : primGain);
            if (!twoChannel)
            begin
                muxCnt_q <= 13'h0000;
                currSecondarySel <= 1'b0;
            end
            else if (iValid)
            begin
                if (muxCnt_q == 13'(MUX_LEN - 1))
                begin
                    muxCnt_q <= 13'h0000;
                    currSecondarySel <= !currSecondarySel;
                end
                else
                begin
                    muxCnt_q <= muxCnt_q + 13'h0001;
                end
            end
        end
    end

    // ************************************************************
    // Decimation and line period monitor
    // ************************************************************

    sd_decimator #(
        .OUT_W(VOLT_W),
        .GAIN_NUM(VOLT_GAIN_NUM),
        .GAIN_SH(VOLT_GAIN_SH)
    ) voltDecim (
        .mclk(mclk),
        .rst_b(rst_b),
        .sampleEn(sampleEn_q),
        .bitIn(vSync_q[1]),
        .sampleOut(vSample),
        .sampleValid(vValid)
    );

    sd_decimator #(
        .OUT_W(CURR_W),
        .GAIN_NUM(CURR_GAIN_NUM),
        .GAIN_SH(CURR_GAIN_SH)
    ) currDecim (
        .mclk(mclk),
        .rst_b(rst_b),
        .sampleEn(sampleEn_q),
        .bitIn(iSync_q[1]),
        .sampleOut(iSample),
        .sampleValid(iValid)
    );

    line_period_monitor #(
        .LOW_CNT(LOW_CNT),
        .HIGH_CNT(HIGH_CNT),
        .CNT_W(18)
    ) periodMon (
        .mclk(mclk),
        .rst_b(rst_b),
        .sampleValid(vValid),
        .sample(vSample),
        .periodCount(periodCount),
        .lowFreq(lowFreq),
        .highFreq(highFreq)
    );

    // ************************************************************
    // RMS voltage check
    // ************************************************************
    logic [20:0] msq_q;

    // Compare mean square times Kv squared against the squared limit, so no divider.
    wire [21:0] vSq = 22'(vSample) * 22'(vSample);
    wire signed [22:0] msqDiff = $signed({1'b0, vSq}) - $signed({2'b00, msq_q});
    wire signed [22:0] msqStep = msqDiff >>> RMS_SHIFT;
    wire [17:0] kvSq = 18'(voltageCalibrator) * 18'(voltageCalibrator);
    wire [39:0] msqScaled = 40'(msq_q) * 40'(kvSq);
    wire [39:0] rmsOn = coilSensor ? RMS_ON_COIL : RMS_ON_SHUNT;
    wire [39:0] rmsOff = {rmsOn[37:0], 2'b00};

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            msq_q <= 21'h000000;
            lowRms_q <= 1'b0;
        end
        else if (vValid)
        begin
            msq_q <= 21'($signed({2'b00, msq_q}) + msqStep);
            if (msqScaled < rmsOn)
            begin
                lowRms_q <= 1'b1;
            end
            else if (msqScaled > rmsOff)
            begin
                lowRms_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Energy integration, pulse and stepper outputs
    // ************************************************************
    logic signed [26:0] fundPower_q;
    logic signed [41:0] acc_q;
    logic [23:0] pulseCnt_q;
    logic stepPhase_q;

    wire bfrNow = lowFreq || highFreq || lowRms_q;
    wire signed [26:0] power = 27'(vSample) * 27'(iSample);
    wire signed [26:0] fundStep = (power - fundPower_q) >>> LP_SHIFT;
    wire signed [26:0] powerSel = fundamentalSel ? fundPower_q : power;
    wire signed [41:0] accNext = acc_q + 42'(powerSel);
    wire signed [41:0] thr = $signed({2'b00, pulseConst_q, 8'h00});
    wire posPulse = accNext >= thr;
    wire negPulse = accNext <= -thr;
    wire pulseBusy = pulseCnt_q != 24'h000000;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            baseFreqRangeError <= 1'b0;
            fundPower_q <= '0;
            acc_q <= '0;
            pulseCnt_q <= 24'h000000;
            stepPhase_q <= 1'b0;
            negativePower <= 1'b0;
        end
        else
        begin
            baseFreqRangeError <= bfrNow;
            if (pulseBusy)
            begin
                pulseCnt_q <= pulseCnt_q - 24'h000001;
            end
            if (iValid && !bfrNow)
            begin
                fundPower_q <= fundPower_q + fundStep;
                negativePower <= powerSel < 0;
                if ((posPulse || negPulse) && !pulseBusy)
                begin
                    acc_q <= posPulse ? accNext - thr : accNext + thr;
                    pulseCnt_q <= 24'(PULSE_LEN);
                    stepPhase_q <= !stepPhase_q;
                end
                else
                begin
                    acc_q <= accNext;
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            energyPulseOut <= 1'b0;
            stepperDrivePos <= 1'b0;
            stepperDriveNeg <= 1'b0;
        end
        else
        begin
            energyPulseOut <= pulseBusy && !bfrNow;
            stepperDrivePos <= pulseBusy && !bfrNow && stepPhase_q;
            stepperDriveNeg <= pulseBusy && !bfrNow && !stepPhase_q;
        end
    end

    // total gain = preamp times PGA

endmodule

`default_nettype wire

// ### tb/sd_modulator_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// First-order sigma-delta modulator
// ****************
module sd_modulator_model
(
    input wire logic mclk,
    input var int ampl,
    input var int period,
    output logic bitOut
);
    real acc = 0.0;
    real x;
    int t = 0;
    initial bitOut = 1'b0;
    // one bit per four clocks.
    // The loop quantiser feeds back its own bit, so zero input alternates.
    always @(posedge mclk)
    begin
        t = t + 1;
        if (t % 4 == 0)
        begin
            x = ampl / 1000.0 * $sin(6.2831853 * t / period);
            acc = acc + x - (acc >= 0.0 ? 1.0 : -1.0);
            bitOut <= (acc >= 0.0);
        end
    end
endmodule
`default_nettype wire

// ### tb/metering_front_end_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Output blanking and bus checks
// ****************
module metering_front_end_chk
    import metering_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic baseFreqRangeError,
    input wire logic stepperDrivePos,
    input wire logic stepperDriveNeg,
    input wire logic energyPulseOut
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // Two error cycles in a row, so the registered blanking has acted.
    sequence errHeld;
        baseFreqRangeError ##1 baseFreqRangeError;
    endsequence
    a_blank_pos: assert property (errHeld |-> !stepperDrivePos)
        else $error("stepper pos high during line error");
    a_blank_neg: assert property (errHeld |-> !stepperDriveNeg)
        else $error("stepper neg high during line error");
    a_blank_pulse: assert property (errHeld |-> !energyPulseOut)
        else $error("energy pulse high during line error");
    a_stepper_excl: assert property (!(stepperDrivePos && stepperDriveNeg))
        else $error("both stepper lines high");
    a_pulse_drive: assert property (energyPulseOut |-> stepperDrivePos || stepperDriveNeg)
        else $error("energy pulse without stepper drive");
    a_bus_ready: assert property (hreadyout)
        else $error("bus wait state seen");
    a_bus_okay: assert property (!hresp)
        else $error("bus error response seen");
    a_reset_quiet: assert property ($rose(rst_b) |-> !baseFreqRangeError && !energyPulseOut)
        else $error("outputs active right after reset");
endmodule
bind metering_front_end metering_front_end_chk chk (.mclk(mclk), .rst_b(rst_b),
    .hreadyout(hreadyout), .hresp(hresp), .baseFreqRangeError(baseFreqRangeError),
    .stepperDrivePos(stepperDrivePos), .stepperDriveNeg(stepperDriveNeg),
    .energyPulseOut(energyPulseOut));
`default_nettype wire

// ### tb/metering_front_end_line_check_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Bench for the metering front end
// ****************
module metering_front_end_line_check_bench;
    import metering_pkg::*;
    logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
    logic [1:0] htrans = 0, pgaCode;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, vBit, cBit, secSel, err, sPos, sNeg, energy_pulse_out, negPow;
    int vAmp = 0, vPer = 2000, cAmp = 0, err_total = 0, cmp_count = 0, cyc = 0, i;
    // Rows: two-channel, select, extra bit, primary gain, secondary gain.
    logic [15:0] rows [9] = '{{1'h0, 2'h0, 1'h0, 6'h08, 6'h08}, {1'h0, 2'h0, 1'h1, 6'h10, 6'h10},
        {1'h0, 2'h1, 1'h0, 6'h18, 6'h18}, {1'h0, 2'h1, 1'h1, 6'h20, 6'h20},
        {1'h0, 2'h2, 1'h1, 6'h08, 6'h08}, {1'h0, 2'h3, 1'h0, 6'h20, 6'h20},
        {1'h1, 2'h0, 1'h1, 6'h10, 6'h10}, {1'h1, 2'h2, 1'h0, 6'h08, 6'h08},
        {1'h1, 2'h3, 1'h1, 6'h08, 6'h20}};
    always #5 mclk = ~mclk;
    // Cycle ceiling well above the sum of all bounded waits.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_total++;
            finish_test();
        end
    end
    metering_front_end #(.LOW_CNT(4000), .HIGH_CNT(1000), .PULSE_LEN(20), .MUX_LEN(4)) dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .voltBitPin(vBit),
        .currBitPin(cBit), .currSecondarySel(secSel), .pgaCode(pgaCode),
        .baseFreqRangeError(err), .stepperDrivePos(sPos), .stepperDriveNeg(sNeg),
        .energyPulseOut(energy_pulse_out), .negativePower(negPow));
    sd_modulator_model vMod (.mclk(mclk), .ampl(vAmp), .period(vPer), .bitOut(vBit));
    sd_modulator_model cMod (.mclk(mclk), .ampl(cAmp), .period(vPer), .bitOut(cBit));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    // One single AHB transfer, entered right after a rising edge.
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        r = hrdata;
    endtask
    task automatic waitFor(input int which, input logic lvl, input int lim);
        int n = 0;
        while ((which == 0 ? err : which == 1 ? secSel : energy_pulse_out) !== lvl && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence: reset, decode rows, then the line checks.
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        ahb(32'(OFS_CONFIG), 1'b0, 32'h0, rd);
        chk("config reset", CONFIG_RST, rd);
        ahb(32'(OFS_PULSE_CONST), 1'b0, 32'h0, rd);
        chk("pulse const reset", PULSE_CONST_RST, rd);
        ahb(32'h14, 1'b0, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        waitFor(0, 1'b1, 400);
        chk("error without input", 32'h1, 32'(err));
        ahb(32'(OFS_STATUS), 1'b0, 32'h0, rd);
        chk("low rms and error bits", 32'h3, 32'({rd[3], rd[0]}));
        $display("Test reset done");
        for (i = 0; i < 9; i++)
        begin
            ahb(32'(OFS_CONFIG), 1'b1,
                CONFIG_RST | 32'({rows[i][15], rows[i][12], rows[i][14:13]}), rd);
            ahb(32'(OFS_STATUS), 1'b0, 32'h0, rd);
            chk("gains", 32'({6'h04, 6'h04, rows[i][5:0], rows[i][11:6]}),
                32'(rd[31:8]));
            if (!rows[i][15])
                chk("pga code", 32'(2'(rows[i][11:9] - 3'h1)), 32'(pgaCode));
        end
        // The code register follows the select one clock later, so look one edge on.
        waitFor(1, 1'b1, 2000);
        @(posedge mclk);
        chk("secondary pga", 32'h3, 32'(pgaCode));
        waitFor(1, 1'b0, 2000);
        @(posedge mclk);
        chk("primary pga", 32'h0, 32'(pgaCode));
        $display("Test gain decode done");
        // Fundamental energy is filtered, so its sign stays positive for in-phase inputs.
        ahb(32'(OFS_CONFIG), 1'b1, CONFIG_RST | 32'h10, rd);
        ahb(32'(OFS_PULSE_CONST), 1'b1, 32'h1, rd);
        vAmp <= 800;
        cAmp <= 300;
        waitFor(0, 1'b0, 30000);
        chk("error clears", 32'h0, 32'(err));
        waitFor(2, 1'b1, 10000);
        chk("energy pulse", 32'h1, 32'(energy_pulse_out));
        chk("negative power", 32'h0, 32'(negPow));
        vPer <= 700;
        repeat (600) @(posedge mclk);
        chk("fast once", 32'h0, 32'(err));
        waitFor(0, 1'b1, 4000);
        chk("fast thrice", 32'h1, 32'(err));
        vPer <= 2000;
        waitFor(0, 1'b0, 15000);
        chk("normal again", 32'h0, 32'(err));
        vPer <= 6000;
        waitFor(0, 1'b1, 10000);
        chk("slow line", 32'h1, 32'(err));
        $display("Test line period done");
        ahb(32'(OFS_CONFIG), 1'b1, 32'h8000_2002, rd);
        ahb(32'(OFS_CONFIG), 1'b1, 32'h0000_2003, rd);
        ahb(32'(OFS_CONFIG), 1'b0, 32'h0, rd);
        chk("locked config", 32'h8000_2002, rd);
        rst_b <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        ahb(32'(OFS_CONFIG), 1'b0, 32'h0, rd);
        chk("config after reset", CONFIG_RST, rd);
        $display("Test lock done");
        finish_test();
    end
endmodule
`default_nettype wire
